// file: rtl/rmwc_bit_sync.sv
// Bit clock recovery: realigns on every data edge, decides each bit mid-period.
// Assumes din_i is already synchronised to mclk_i and per_i >= 2.
`timescale 1ns/1ps

module rmwc_bit_sync
	import rmwc_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        en_i,
	input  wire logic        din_i,
	input  wire logic [15:0] per_i,
	output logic             data_o,
	output logic             clk_o,
	output logic             valid_o
);

	typedef struct packed {
		logic [15:0] cnt;
		logic        prev;
		logic        data;
		logic        clk;
		logic        valid;
	} rmwc_bs_st_t;

	rmwc_bs_st_t q, d;

	always_comb begin
		d = q;
		d.valid = 1'b0;
		if (!en_i) begin
			d = '0;
		end else begin
			d.prev = din_i;
			if (din_i != q.prev || q.cnt >= per_i - 16'h1) begin
				d.cnt = 16'h0;
			end else begin
				d.cnt = q.cnt + 16'h1;
			end
			// Data changes half a bit before the rising clock edge
			if (q.cnt == (per_i >> 1)) begin
				d.data = din_i;
				d.valid = 1'b1;
				d.clk = 1'b0;
			end else if (q.cnt == 16'h0) begin
				d.clk = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign data_o = q.data;
	assign clk_o = q.clk;
	assign valid_o = q.valid;

endmodule

// file: rtl/rmwc_tick.sv
// Programmable enable-pulse divider.
// Assumes period_i is at least 1; one pulse every period_i cycles while en_i.
`timescale 1ns/1ps
`include "rmwc_map.svh"

module rmwc_tick
	import rmwc_pkg::*;
(
	input  wire logic                    mclk_i,
	input  wire logic                    sys_rst_i,
	input  wire logic                    en_i,
	input  wire logic [`RMWC_TICK_W-1:0] period_i,
	output logic                         tick_o
);

	typedef struct packed {
		logic [`RMWC_TICK_W-1:0] cnt;
		logic                    tick;
	} rmwc_tick_st_t;

	rmwc_tick_st_t q, d;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (!en_i) begin
			d.cnt = '0;
		end else if (q.cnt >= period_i - `RMWC_TICK_W'(1)) begin
			d.cnt = '0;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + `RMWC_TICK_W'(1);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick_o = q.tick;

endmodule

// file: rtl/rmwc_top.sv
// Mode, data path and wake-up control of the radio transceiver.
// Assumes a serial port block decodes host accesses into the cfg ports
// below and pulses host_access_i on every completed access.
// Contract
// [R1] Configuration and status travel only through the three-wire serial port.
// [R2] Extended enable low: legacy behaviour, no additional features.
// [R3] Extended enable high: features available; legacy while divider keeps reset value.
// [R4] After reset, extended enable is cleared and behaviour is legacy.
// [R5] Extended mode may shorten converter clock from 12 us to 1.5 us.
// [R6] Auxiliary output carries one of seven selectable sources.
// [R7] Carrier detect is high exactly while RSSI exceeds the threshold.
// [R8] Power-down keeps only the control interface alive.
// [R9] Oscillator mode runs only the crystal, optionally buffered onto auxiliary output.
// [R10] Async transmit: data pin level drives the modulator directly.
// [R11] Async receive: demodulated bits go to data pin, no clock.
// [R12] Host does any line coding in asynchronous modes.
// [R13] Sync receive: recovered clock, on-chip bit decision, aligned jitter-free data.
// [R14] Sleep: timer periodically enables reception, scanning until message matches.
// [R15] On match, store up to 32 data bits and raise wake-up output.
// [R16] Data paths support bit rates up to 100 kbps.
// [R17] Host clock divide ratio comes from divider configuration bits 20 to 14.
// [R18] Wake-up output holds until host accesses the device.
`timescale 1ns/1ps
`include "rmwc_map.svh"

module rmwc_top
	import rmwc_pkg::*;
#(
	parameter logic [`RMWC_TICK_W-1:0] KHZ_HALF_CYC = `RMWC_TICK_W'(`RMWC_KHZ_HALF_CYC)
)
(
	input  wire logic                    mclk_i,
	input  wire logic                    sys_rst_i,
	input  wire logic                    host_access_i,
	input  wire logic                    ext_feat_en_i,
	input  wire logic [6:0]              div_cfg_i,
	input  wire logic                    fast_rssi_i,
	input  wire logic [2:0]              aux_sel_i,
	input  wire logic [2:0]              op_mode_i,
	input  wire logic [7:0]              carrier_threshold_i,
	input  wire logic [15:0]             bit_period_i,
	input  wire logic [7:0]              scan_interval_i,
	input  wire logic [`RMWC_PAT_W-1:0]  wake_pattern_i,
	input  wire logic [7:0]              rssi_i,
	input  wire logic                    rx_demod_i,
	input  wire logic                    disc455_i,
	input  wire logic                    synth_lock_i,
	input  wire logic                    message_data_pin_i,
	output logic                         message_data_pin_o,
	output logic                         message_data_pin_oe_o,
	output logic                         modulator_o,
	output logic                         data_clk_o,
	output logic                         auxiliary_digital_output_o,
	output logic                         wakeup_o,
	output logic [`RMWC_DATA_W-1:0]      wake_data_o,
	output logic [7:0]                   rssi_o,
	output logic                         rssi_conv_o,
	output logic                         radio_en_o,
	output logic                         osc_run_o
);

	typedef struct packed {
		logic                   rx_s1;
		logic                   rx_s2;
		logic                   d455_s1;
		logic                   d455_s2;
		logic                   lock_s1;
		logic                   lock_s2;
		logic                   msg_s1;
		logic                   msg_s2;
		logic                   ext;
		logic [6:0]             div;
		logic [6:0]             ref_cnt;
		logic                   ref_clk;
		logic                   khz;
		logic [7:0]             rssi;
		logic                   rssi_smp;
		logic                   cd;
		logic                   aux;
		logic                   mod;
		logic                   dout;
		logic                   doe;
		logic                   dclk;
		logic                   radio;
		logic                   osc;
		rmwc_mode_t             mode;
		rmwc_wk_t               wst;
		logic [7:0]             scan_cnt;
		logic [7:0]             win_cnt;
		logic [5:0]             bit_cnt;
		logic [`RMWC_PAT_W-1:0] shift;
		logic [`RMWC_DATA_W-1:0] wdata;
		logic                   wake;
	} rmwc_top_st_t;

	rmwc_top_st_t q, d;

	logic                    rssi_tick;
	logic                    khz_tick;
	logic                    bs_data;
	logic                    bs_clk;
	logic                    bs_valid;
	logic                    rx_on;
	logic                    bs_en;
	logic                    ms_tick;
	logic                    power_down_mode;
	logic [15:0]             bit_per;
	logic [`RMWC_TICK_W-1:0] rssi_per;
	rmwc_mode_t              mode_now;

	assign mode_now = rmwc_mode_t'(op_mode_i);
	assign power_down_mode = (q.mode == MODE_PDN);
	// Listening in sleep mode only during the scan window or capture
	assign rx_on = (q.mode == MODE_RXA) || (q.mode == MODE_RXS) ||
		(q.mode == MODE_SLEEP && (q.wst == WK_HUNT || q.wst == WK_CAPT));
	assign bs_en = (q.mode == MODE_RXS) || (q.mode == MODE_SLEEP && rx_on);
	// Shorter periods than 100 kbps are clamped
	assign bit_per = (bit_period_i < 16'(`RMWC_BIT_MIN_CYC)) ? 16'(`RMWC_BIT_MIN_CYC) : bit_period_i; // [R16]
	assign rssi_per = (q.ext && fast_rssi_i) ? `RMWC_TICK_W'(`RMWC_RSSI_FAST_CYC) :
		`RMWC_TICK_W'(`RMWC_RSSI_SLOW_CYC); // [R5]
	assign ms_tick = khz_tick && q.khz;

	rmwc_tick u_rssi_tick (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.en_i      (rx_on),
		.period_i  (rssi_per),
		.tick_o    (rssi_tick)
	);

	rmwc_tick u_khz_tick (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.en_i      (!power_down_mode),
		.period_i  (KHZ_HALF_CYC),
		.tick_o    (khz_tick)
	);

	rmwc_bit_sync u_bit_sync (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.en_i      (bs_en),
		.din_i     (q.rx_s2),
		.per_i     (bit_per),
		.data_o    (bs_data),
		.clk_o     (bs_clk),
		.valid_o   (bs_valid)
	);

	always_comb begin
		d = q;
		d.rx_s1 = rx_demod_i;
		d.rx_s2 = q.rx_s1;
		d.d455_s1 = disc455_i;
		d.d455_s2 = q.d455_s1;
		d.lock_s1 = synth_lock_i;
		d.lock_s2 = q.lock_s1;
		d.msg_s1 = message_data_pin_i;
		d.msg_s2 = q.msg_s1;
		// Settings arrive from the serial port decoder only
		d.mode = mode_now; // [R1]
		d.ext = ext_feat_en_i; // [R2] [R4]
		// The divider only leaves its legacy value in extended mode
		d.div = ext_feat_en_i ? div_cfg_i : `RMWC_DIV_RESET; // [R3] [R17]
		d.osc = !power_down_mode; // [R8]

		// Divided reference clock for the host
		if (power_down_mode) begin
			d.ref_cnt = 7'h00;
			d.ref_clk = 1'b0;
		end else if (q.ref_cnt >= q.div) begin
			d.ref_cnt = 7'h00;
			d.ref_clk = !q.ref_clk; // [R17] [R9]
		end else begin
			d.ref_cnt = q.ref_cnt + 7'h01;
		end

		if (power_down_mode) begin
			d.khz = 1'b0;
		end else if (khz_tick) begin
			d.khz = !q.khz;
		end

		d.rssi_smp = 1'b0;
		if (rssi_tick) begin
			d.rssi = rssi_i;
			d.rssi_smp = 1'b1;
		end
		d.cd = (q.rssi > carrier_threshold_i); // [R7]

		// Auxiliary output stays low in legacy mode
		if (!q.ext || power_down_mode) begin
			d.aux = 1'b0; // [R2] [R8]
		end else begin
			case (rmwc_aux_t'(aux_sel_i)) // [R6]
				AUX_REFCLK: begin
					d.aux = q.ref_clk; // [R9]
				end
				AUX_CARRIER: begin
					d.aux = q.cd;
				end
				AUX_OSCRUN: begin
					d.aux = q.osc;
				end
				AUX_DISC455: begin
					d.aux = q.d455_s2;
				end
				AUX_RXMODE: begin
					d.aux = rx_on;
				end
				AUX_KHZ: begin
					d.aux = q.khz;
				end
				AUX_LOCK: begin
					d.aux = q.lock_s2;
				end
				default: begin
					d.aux = 1'b0;
				end
			endcase
		end

		// Data path: only the one path of the current mode is live
		d.mod = 1'b0;
		d.dout = 1'b0;
		d.doe = 1'b0;
		d.dclk = 1'b0;
		case (q.mode)
			MODE_TX: begin
				// The two-stage pin synchroniser and the modulator register lie between pin and modulator
				d.mod = q.msg_s2; // [R10] [R12]
			end
			MODE_RXA: begin
				d.doe = 1'b1;
				d.dout = q.rx_s2; // [R11] [R12]
			end
			MODE_RXS: begin
				d.doe = 1'b1;
				d.dout = bs_data; // [R13]
				d.dclk = bs_clk; // [R13]
			end
			default: begin
				d.mod = 1'b0;
			end
		endcase
		d.radio = rx_on || (q.mode == MODE_TX); // [R8] [R9]

		// Wake-up scan
		if (q.mode != MODE_SLEEP) begin
			d.wst = WK_OFF;
		end else begin
			case (q.wst)
				WK_OFF: begin
					d.wst = WK_SLEEP;
					d.scan_cnt = 8'h00;
				end
				WK_SLEEP: begin
					if (ms_tick) begin
						if (q.scan_cnt >= scan_interval_i) begin
							d.wst = WK_HUNT; // [R14]
							d.win_cnt = 8'h00;
							d.shift = '0;
						end else begin
							d.scan_cnt = q.scan_cnt + 8'h01;
						end
					end
				end
				WK_HUNT: begin
					if (bs_valid) begin
						d.shift = {q.shift[`RMWC_PAT_W-2:0], bs_data};
					end
					if (q.shift == wake_pattern_i) begin
						d.wst = WK_CAPT;
						d.bit_cnt = 6'h00;
					end else if (ms_tick) begin
						if (q.win_cnt >= `RMWC_LISTEN_MS) begin
							// No match: back to sleep and scan again
							d.wst = WK_SLEEP; // [R14]
							d.scan_cnt = 8'h00;
						end else begin
							d.win_cnt = q.win_cnt + 8'h01;
						end
					end
				end
				WK_CAPT: begin
					if (bs_valid) begin
						d.wdata = {q.wdata[`RMWC_DATA_W-2:0], bs_data}; // [R15]
						d.bit_cnt = q.bit_cnt + 6'h01;
						if (q.bit_cnt == 6'(`RMWC_DATA_W - 1)) begin
							d.wst = WK_DONE;
						end
					end
				end
				WK_DONE: begin
					d.wst = WK_DONE;
				end
				default: begin
					d.wst = WK_OFF;
				end
			endcase
		end

		// A capture completing in the same cycle as a host access wins
		if (q.wst == WK_CAPT && bs_valid && q.bit_cnt == 6'(`RMWC_DATA_W - 1)) begin
			d.wake = 1'b1; // [R15]
		end else if (host_access_i || mode_now != q.mode) begin
			d.wake = 1'b0; // [R18]
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			q <= '0;
			q.mode <= MODE_PDN;
			q.wst <= WK_OFF;
			q.div <= `RMWC_DIV_RESET;
		end else begin
			q <= d;
		end
	end

	assign message_data_pin_o = q.dout;
	assign message_data_pin_oe_o = q.doe;
	assign modulator_o = q.mod;
	assign data_clk_o = q.dclk;
	assign auxiliary_digital_output_o = q.aux;
	assign wakeup_o = q.wake;
	assign wake_data_o = q.wdata;
	assign rssi_o = q.rssi;
	assign rssi_conv_o = q.rssi_smp;
	assign radio_en_o = q.radio;
	assign osc_run_o = q.osc;

endmodule

// file: shared/rmwc_map.svh
// Constants for the radio mode and wake-up control block.
// Assumes mclk_i is the reference oscillator clock at 125 MHz.
`ifndef RMWC_MAP_SVH
`define RMWC_MAP_SVH

`define RMWC_CLK_MHZ         125
// Converter clock periods, in ns
`define RMWC_RSSI_SLOW_NS    12000
`define RMWC_RSSI_FAST_NS    1500
`define RMWC_RSSI_SLOW_CYC   ((`RMWC_RSSI_SLOW_NS * `RMWC_CLK_MHZ) / 1000)
`define RMWC_RSSI_FAST_CYC   ((`RMWC_RSSI_FAST_NS * `RMWC_CLK_MHZ) / 1000)
// Half period of the 1 kHz wake-up timer clock, in ns
`define RMWC_KHZ_HALF_NS     500000
`define RMWC_KHZ_HALF_CYC    ((`RMWC_KHZ_HALF_NS * `RMWC_CLK_MHZ) / 1000)
// Highest bit rate, in kbps, and the shortest bit period it allows
`define RMWC_MAX_KBPS        100
`define RMWC_BIT_MIN_CYC     ((`RMWC_CLK_MHZ * 1000) / `RMWC_MAX_KBPS)
// Divider setting at reset: the legacy-compatible value
`define RMWC_DIV_RESET       7'h00
// Listen window of one wake-up scan, in timer milliseconds
`define RMWC_LISTEN_MS       8'h10
`define RMWC_PAT_W           16
`define RMWC_DATA_W          32
`define RMWC_TICK_W          17

`endif

// file: shared/rmwc_pkg.sv
// Types of the radio mode and wake-up control block.
// Includes rmwc_map.svh; all three enums are fixed at 3 bits.
`include "rmwc_map.svh"

package rmwc_pkg;

	typedef enum logic [2:0] {
		MODE_PDN   = 3'h0,
		MODE_OSC   = 3'h1,
		MODE_IDLE  = 3'h2,
		MODE_TX    = 3'h3,
		MODE_RXA   = 3'h4,
		MODE_RXS   = 3'h5,
		MODE_SLEEP = 3'h6
	} rmwc_mode_t;

	typedef enum logic [2:0] {
		AUX_REFCLK = 3'h0,
		AUX_CARRIER = 3'h1,
		AUX_OSCRUN = 3'h2,
		AUX_DISC455 = 3'h3,
		AUX_RXMODE = 3'h4,
		AUX_KHZ = 3'h5,
		AUX_LOCK = 3'h6
	} rmwc_aux_t;

	typedef enum logic [2:0] {
		WK_OFF   = 3'h0,
		WK_SLEEP = 3'h1,
		WK_HUNT  = 3'h2,
		WK_CAPT  = 3'h3,
		WK_DONE  = 3'h4
	} rmwc_wk_t;

endpackage

// file: tb/rmwc_chk.sv
// Port checks of rmwc_top: reset, power-down, pipes, aux gating, wake flag.
// Bound to rmwc_top from the bench top file.
`timescale 1ns/1ps
module rmwc_chk
	import rmwc_pkg::*;
(
	input wire logic       mclk_i,
	input wire logic       sys_rst_i,
	input wire logic       host_access_i,
	input wire logic       ext_feat_en_i,
	input wire logic [2:0] aux_sel_i,
	input wire logic [2:0] op_mode_i,
	input wire logic [7:0] carrier_threshold_i,
	input wire logic       rx_demod_i,
	input wire logic       message_data_pin_i,
	input wire logic       message_data_pin_o,
	input wire logic       message_data_pin_oe_o,
	input wire logic       modulator_o,
	input wire logic       auxiliary_digital_output_o,
	input wire logic       wakeup_o,
	input wire logic [7:0] rssi_o,
	input wire logic       radio_en_o,
	input wire logic       osc_run_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);

	AST_RST_QUIET: assert property (disable iff (1'b0) sys_rst_i |=>
		!(wakeup_o | radio_en_o | osc_run_o | auxiliary_digital_output_o | message_data_pin_oe_o))
		else $error("output active after reset");
	AST_PDN_DARK: assert property ((op_mode_i == 3'h0)[*3] |->
		!(osc_run_o | radio_en_o | auxiliary_digital_output_o | message_data_pin_oe_o))
		else $error("activity in power-down");
	AST_TX_PIPE: assert property ((op_mode_i == 3'h3)[*6] |->
		modulator_o == $past(message_data_pin_i, 3) && !message_data_pin_oe_o)
		else $error("modulator does not follow pin");
	AST_RX_PIPE: assert property ((op_mode_i == 3'h4)[*6] |->
		message_data_pin_oe_o && message_data_pin_o == $past(rx_demod_i, 3))
		else $error("pin does not follow demodulator");
	AST_LEGACY_AUX: assert property ((!ext_feat_en_i)[*3] |-> !auxiliary_digital_output_o)
		else $error("aux active in legacy mode");
	AST_CARRIER: assert property ((ext_feat_en_i && aux_sel_i == 3'h1 && op_mode_i != 3'h0)[*4] |->
		auxiliary_digital_output_o == ($past(rssi_o, 2) > $past(carrier_threshold_i, 2)))
		else $error("carrier detect wrong");
	AST_WAKE_HOLD: assert property (wakeup_o && !host_access_i && !$past(host_access_i) &&
		$stable(op_mode_i) && $past(op_mode_i, 2) == op_mode_i |=> wakeup_o)
		else $error("wake flag dropped without access");
	AST_WAKE_CLEAR: assert property (wakeup_o && host_access_i |=> !wakeup_o)
		else $error("wake flag not cleared by access");

	cover property ($rose(wakeup_o));
	cover property (auxiliary_digital_output_o && aux_sel_i == 3'h1);
	cover property ($rose(modulator_o) && op_mode_i == 3'h3);
	cover property ($rose(message_data_pin_oe_o) && op_mode_i == 3'h5);
endmodule

// file: tb/rmwc_far_model.sv
// Far-side bit source: the controller on the data pin, or the demodulated stream.
// Sends nbits_i bits of bits_i, first bit in bit 63, each held per_i cycles.
`timescale 1ns/1ps
module rmwc_far_model (
	input  wire logic        mclk_i,
	input  wire logic        start_i,
	input  wire logic [15:0] per_i,
	input  wire logic [6:0]  nbits_i,
	input  wire logic [63:0] bits_i,
	output logic             line_o
);
	logic [63:0] sh_q = '0;
	logic [15:0] cnt_q = '0;
	logic [6:0]  left_q = '0;
	// Plain NRZ; any line coding is the sender's own job
	assign line_o = sh_q[63];
	// Plain always: the initial values keep the line low before the first frame
	always @(posedge mclk_i) begin
		if (start_i) begin
			sh_q <= bits_i;
			cnt_q <= per_i;
			left_q <= nbits_i;
		end else if (left_q != 7'h00) begin
			if (cnt_q == 16'h0001) begin
				sh_q <= {sh_q[62:0], 1'b0};
				cnt_q <= per_i;
				left_q <= left_q - 7'h01;
			end else begin
				cnt_q <= cnt_q - 16'h0001;
			end
		end
	end
endmodule

// file: tb/rmwc_tb.sv
// Bench for rmwc_top: power modes, pipes, aux sources, converter rate, wake-up.
// Needs rmwc_pkg, rmwc_far_model and rmwc_chk compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
	begin \
		comparisons++; \
		if ((got) !== (ex)) begin \
			err_total++; \
			$display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
		end \
	end
module rmwc_tb;
	import rmwc_pkg::*;
	localparam logic [15:0] BITP = 16'h04e2;
	localparam logic [31:0] WDAT = 32'h5a3c96e1;
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;
	logic mclk_i = 1'b0, sys_rst_i = 1'b1, host_access_i = 1'b0, ext_feat_en_i = 1'b0;
	logic fast_rssi_i = 1'b0, disc455_i = 1'b0, synth_lock_i = 1'b0, go_host = 1'b0, go_air = 1'b0;
	logic host_line, rx_demod_i, message_data_pin_i, message_data_pin_o, message_data_pin_oe_o;
	logic modulator_o, data_clk_o, auxiliary_digital_output_o, wakeup_o, rssi_conv_o, radio_en_o, osc_run_o;
	logic [6:0]  div_cfg_i = 7'h00, nbits = 7'h00;
	logic [2:0]  aux_sel_i = 3'h0, op_mode_i = 3'h0;
	logic [7:0]  carrier_threshold_i = 8'h00, rssi_i = 8'h80, scan_interval_i = 8'h00, rssi_o;
	logic [15:0] bit_period_i = BITP, wake_pattern_i = 16'hd2a7;
	logic [31:0] wake_data_o;
	logic [63:0] bits = '0;

	// Whoever has the pin enabled sets its level
	assign message_data_pin_i = message_data_pin_oe_o ? message_data_pin_o : host_line;
	rmwc_top #(.KHZ_HALF_CYC(17'h002bc)) u_rmwc_top (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .host_access_i(host_access_i),
		.ext_feat_en_i(ext_feat_en_i), .div_cfg_i(div_cfg_i), .fast_rssi_i(fast_rssi_i),
		.aux_sel_i(aux_sel_i), .op_mode_i(op_mode_i), .carrier_threshold_i(carrier_threshold_i),
		.bit_period_i(bit_period_i), .scan_interval_i(scan_interval_i), .wake_pattern_i(wake_pattern_i),
		.rssi_i(rssi_i), .rx_demod_i(rx_demod_i), .disc455_i(disc455_i), .synth_lock_i(synth_lock_i),
		.message_data_pin_i(message_data_pin_i), .message_data_pin_o(message_data_pin_o),
		.message_data_pin_oe_o(message_data_pin_oe_o), .modulator_o(modulator_o), .data_clk_o(data_clk_o),
		.auxiliary_digital_output_o(auxiliary_digital_output_o), .wakeup_o(wakeup_o),
		.wake_data_o(wake_data_o), .rssi_o(rssi_o), .rssi_conv_o(rssi_conv_o),
		.radio_en_o(radio_en_o), .osc_run_o(osc_run_o)
	);
	rmwc_far_model u_rmwc_far_model_host (.mclk_i(mclk_i), .start_i(go_host), .per_i(BITP),
		.nbits_i(nbits), .bits_i(bits), .line_o(host_line));
	rmwc_far_model u_rmwc_far_model_air (.mclk_i(mclk_i), .start_i(go_air), .per_i(BITP),
		.nbits_i(nbits), .bits_i(bits), .line_o(rx_demod_i));

	initial begin
		forever #4 mclk_i = ~mclk_i;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic send(input logic air, input logic [6:0] n, input logic [63:0] v);
		bits = v;
		nbits = n;
		go_air = air;
		go_host = !air;
		cyc(1);
		go_air = 1'b0;
		go_host = 1'b0;
	endtask

	task automatic pipe(input logic air, input logic [5:0] v);
		send(air, 7'h06, {v, 58'h0});
		cyc(625);
		for (int k = 5; k >= 0; k--) begin
			if (air) `CHK("rx pipe", v[k], message_data_pin_o)
			else `CHK("tx pipe", v[k], modulator_o)
			cyc(1250);
		end
	endtask

	task automatic aux(input logic [2:0] s, input logic e);
		aux_sel_i = s;
		cyc(8);
		`CHK("aux source", e, auxiliary_digital_output_o)
	endtask

	task automatic flips(input logic [2:0] s, input int len, input int ex);
		int n;
		logic p;
		n = 0;
		aux_sel_i = s;
		cyc(8);
		p = auxiliary_digital_output_o;
		repeat (len) begin
			cyc(1);
			if (auxiliary_digital_output_o !== p) n++;
			p = auxiliary_digital_output_o;
		end
		`CHK("aux toggles", ex, n)
	endtask

	// First loop only syncs to a pulse; the second measures a whole period
	task automatic gap(input logic e, input logic f, input int ex);
		int n;
		ext_feat_en_i = e;
		fast_rssi_i = f;
		for (int i = 0; i < 2; i++) begin
			n = 1;
			cyc(1);
			while (rssi_conv_o !== 1'b1 && n < 4000) begin
				cyc(1);
				n++;
			end
		end
		`CHK("converter period", ex, n)
	endtask

	task automatic t_modes();
		ext_feat_en_i = 1'b1;
		aux_sel_i = 3'h2;
		cyc(6);
		`CHK("power-down", 1'b0, osc_run_o | radio_en_o | auxiliary_digital_output_o)
		op_mode_i = 3'h1;
		cyc(6);
		`CHK("osc only", 3'h5, {osc_run_o, radio_en_o, auxiliary_digital_output_o})
		ext_feat_en_i = 1'b0;
		cyc(6);
		`CHK("legacy aux", 1'b0, auxiliary_digital_output_o)
		ext_feat_en_i = 1'b1;
		op_mode_i = 3'h3;
		cyc(4);
		`CHK("tx pin free", 1'b0, message_data_pin_oe_o)
		pipe(1'b0, 6'h2d);
		op_mode_i = 3'h4;
		cyc(4);
		`CHK("rx pin driven", 1'b1, message_data_pin_oe_o)
		pipe(1'b1, 6'h19);
	endtask

	task automatic t_aux();
		fast_rssi_i = 1'b1;
		carrier_threshold_i = 8'h7f;
		aux_sel_i = 3'h1;
		cyc(400);
		`CHK("carrier above", 1'b1, auxiliary_digital_output_o)
		carrier_threshold_i = 8'h80;
		cyc(8);
		`CHK("carrier equal", 1'b0, auxiliary_digital_output_o)
		`CHK("rssi level", 8'h80, rssi_o)
		aux(3'h2, 1'b1);
		aux(3'h4, 1'b1);
		disc455_i = 1'b1;
		aux(3'h3, 1'b1);
		synth_lock_i = 1'b1;
		aux(3'h6, 1'b1);
		synth_lock_i = 1'b0;
		aux(3'h6, 1'b0);
		aux(3'h7, 1'b0);
		div_cfg_i = 7'h03;
		flips(3'h0, 80, 20);
		flips(3'h5, 2800, 4);
		gap(1'b1, 1'b1, 187);
		gap(1'b1, 1'b0, 1500);
		gap(1'b0, 1'b1, 1500);
		ext_feat_en_i = 1'b1;
	endtask

	// Sync receive: data settles at mid-bit with the clock low, clock high from the next bit edge
	task automatic t_sync();
		logic [3:0] v;
		v = 4'hb;
		op_mode_i = 3'h5;
		// Too short a period: the design must clamp it to the 100 kbps bit time
		bit_period_i = 16'h0100;
		cyc(4);
		`CHK("sync pin driven", 1'b1, message_data_pin_oe_o)
		send(1'b1, 7'h04, {v, 60'h0});
		cyc(930);
		for (int k = 3; k >= 0; k--) begin
			`CHK("sync data", v[k], message_data_pin_o)
			`CHK("sync clock low", 1'b0, data_clk_o)
			cyc(625);
			`CHK("sync clock high", 1'b1, data_clk_o)
			cyc(625);
		end
		bit_period_i = BITP;
	endtask

	task automatic t_wake();
		int n;
		n = 0;
		op_mode_i = 3'h6;
		cyc(4);
		`CHK("asleep", 1'b0, radio_en_o)
		while (radio_en_o !== 1'b1 && n < 4000) begin
			cyc(1);
			n++;
		end
		`CHK("scan opens", 1'b1, radio_en_o)
		send(1'b1, 7'h30, {16'hd2a7, WDAT, 16'h0000});
		n = 0;
		while (wakeup_o !== 1'b1 && n < 70000) begin
			cyc(1);
			n++;
		end
		`CHK("wake flag", 1'b1, wakeup_o)
		`CHK("wake data", WDAT, wake_data_o)
		cyc(40);
		`CHK("wake held", 1'b1, wakeup_o)
		host_access_i = 1'b1;
		cyc(1);
		host_access_i = 1'b0;
		cyc(2);
		`CHK("wake cleared", 1'b0, wakeup_o)
	endtask

	initial begin
		cyc(20);
		`CHK("reset quiet", 1'b0, osc_run_o | wakeup_o | radio_en_o)
		sys_rst_i = 1'b0;
		t_modes();
		t_aux();
		t_sync();
		t_wake();
		summarize();
	end

	// Ceiling sits just above the expected run length
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles > 100000) begin
			err_total++;
			summarize();
		end
	end
endmodule

bind rmwc_top rmwc_chk u_rmwc_chk (
	.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .host_access_i(host_access_i), .ext_feat_en_i(ext_feat_en_i),
	.aux_sel_i(aux_sel_i), .op_mode_i(op_mode_i), .carrier_threshold_i(carrier_threshold_i),
	.rx_demod_i(rx_demod_i), .message_data_pin_i(message_data_pin_i), .message_data_pin_o(message_data_pin_o),
	.message_data_pin_oe_o(message_data_pin_oe_o), .modulator_o(modulator_o),
	.auxiliary_digital_output_o(auxiliary_digital_output_o), .wakeup_o(wakeup_o), .rssi_o(rssi_o),
	.radio_en_o(radio_en_o), .osc_run_o(osc_run_o)
);
